// ---- design/sflc_top.v ----
/*
 Serial frame and loop control: control registers, pin routing,
 character transmitter and receiver, idle detection, transmit FIFO.
 Assumes synchronous inputs on clk, a synchronous active-high reset,
 and that the pad logic resolves the shared line from the enable.
*/
`timescale 1ns/1ns
`include "sflc_defs.vh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module sflc_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output reg in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	localparam [31:0] FULL_COUNT_W = DEPTH;
	localparam [AW:0] FULL_COUNT = FULL_COUNT_W[AW:0];
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	reg [AW:0] count_next;
	wire push;
	wire pop;

	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @* begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + 1'b1;
		else if (pop & ~push)
			count_next = count_reg - 1'b1;
	end

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			in_ready <= (count_next != FULL_COUNT);
		end
	end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module sflc_top #(
	parameter BIT_CYCLES = 16,
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW = 5
) (
	input wire clk,
	input wire rst,
	input wire [15:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_wdata,
	output reg [7:0] bus_rdata,
	input wire [8:0] tx_data,
	input wire tx_valid,
	output wire tx_ready,
	output reg [8:0] rx_data,
	output reg rx_strobe,
	output reg rx_parity_err,
	output reg rx_frame_err,
	output reg idle_strobe,
	input wire serial_in_pin,
	output reg serial_in_released,
	input wire serial_out_pin_in,
	output reg serial_out_pin_out,
	output reg serial_out_pin_oe_n
);
	localparam [31:0] BIT_LAST_W = BIT_CYCLES - 1;
	localparam [31:0] BIT_HALF_W = BIT_CYCLES / 2 - 1;
	localparam [15:0] BIT_LAST = BIT_LAST_W[15:0];
	localparam [15:0] BIT_HALF = BIT_HALF_W[15:0];
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;

	function addr_hit;
		input [15:0] a;
		input [15:0] off;
		begin
			addr_hit = (a == `SFLC_BASE_BLOCKING + off) ||
				(a == `SFLC_BASE_NONBLOCK + off);
		end
	endfunction

	// Parity value that makes the ones count even or odd
	function parity_bit;
		input [8:0] d;
		input nine;
		input odd;
		begin
			parity_bit = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
		end
	endfunction

	reg [7:0] ctrl1_reg;
	reg [7:0] ctrl2_reg;
	reg [7:0] ctrl3_reg;
	wire loop_sel = ctrl1_reg[`SFLC_C1_LOOP];
	wire swire_sel = ctrl1_reg[`SFLC_C1_SWIRE];
	wire nine_sel = ctrl1_reg[`SFLC_C1_NINE];
	wire ilt_sel = ctrl1_reg[`SFLC_C1_ILT];
	wire pe_sel = ctrl1_reg[`SFLC_C1_PE];
	wire pt_sel = ctrl1_reg[`SFLC_C1_PT];
	wire tx_on = ctrl2_reg[`SFLC_C2_TE];
	wire rx_on = ctrl2_reg[`SFLC_C2_RE];
	wire rwu_sel = ctrl2_reg[`SFLC_C2_RWU];
	wire sbk_sel = ctrl2_reg[`SFLC_C2_SBK];
	wire dir_sel = ctrl3_reg[`SFLC_C3_DIR];
	wire [3:0] frame_bits = nine_sel ? `SFLC_FRAME_BITS_9 :
		`SFLC_FRAME_BITS_8;
	wire single_wire = loop_sel & swire_sel;

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	wire hit1 = addr_hit(bus_addr, `SFLC_OFF_CTRL1);
	wire hit2 = addr_hit(bus_addr, `SFLC_OFF_CTRL2);
	wire hit3 = addr_hit(bus_addr, `SFLC_OFF_CTRL3);

	always @(posedge clk) begin
		if (rst) begin
			ctrl1_reg <= `SFLC_CTRL1_RESET;
			ctrl2_reg <= `SFLC_CTRL2_RESET;
			ctrl3_reg <= `SFLC_CTRL3_RESET;
			bus_rdata <= 8'h00;
		end else begin
			if (bus_wr) begin
				if (hit1)
					ctrl1_reg <= bus_wdata;
				else if (hit2)
					ctrl2_reg <= bus_wdata;
				else if (hit3)
					ctrl3_reg <= bus_wdata & 8'h20;
			end
			if (bus_rd) begin
				if (hit1)
					bus_rdata <= ctrl1_reg;
				else if (hit2)
					bus_rdata <= ctrl2_reg;
				else if (hit3)
					bus_rdata <= ctrl3_reg;
				else
					bus_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	reg tx_state_reg;
	reg [10:0] tx_shift_reg;
	reg [3:0] tx_left_reg;
	reg [15:0] tx_tmr_reg;
	reg tx_line_reg;
	wire [8:0] fifo_data;
	wire fifo_valid;
	wire fifo_pop = (tx_state_reg == ST_IDLE) & tx_on & ~sbk_sel;
	reg [8:0] tx_char;
	reg [10:0] tx_frame;

	sflc_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	always @* begin
		tx_char = fifo_data;
		if (pe_sel) begin
			if (nine_sel)
				tx_char[8] = parity_bit(fifo_data, 1'b1, pt_sel);
			else
				tx_char[7] = parity_bit(fifo_data, 1'b0, pt_sel);
		end
		if (nine_sel)
			tx_frame = {1'b1, tx_char, 1'b0};
		else
			tx_frame = {2'b11, tx_char[7:0], 1'b0};
	end

	always @(posedge clk) begin
		if (rst) begin
			tx_state_reg <= ST_IDLE;
			tx_shift_reg <= 11'h7ff;
			tx_left_reg <= 4'h0;
			tx_tmr_reg <= 16'h0000;
			tx_line_reg <= 1'b1;
		end else begin
			case (tx_state_reg)
			ST_IDLE: begin
				if (fifo_pop & fifo_valid) begin
					tx_line_reg <= tx_frame[0];
					tx_shift_reg <= {1'b1, tx_frame[10:1]};
					tx_left_reg <= frame_bits - 1'b1;
					tx_tmr_reg <= BIT_LAST;
					tx_state_reg <= ST_BUSY;
				end else begin
					tx_line_reg <= ~(sbk_sel & tx_on);
				end
			end
			default: begin
				if (tx_tmr_reg == 16'h0000) begin
					tx_tmr_reg <= BIT_LAST;
					if (tx_left_reg == 4'h0) begin
						tx_state_reg <= ST_IDLE;
						tx_line_reg <= 1'b1;
					end else begin
						tx_line_reg <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
						tx_left_reg <= tx_left_reg - 1'b1;
					end
				end else begin
					tx_tmr_reg <= tx_tmr_reg - 1'b1;
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	wire rx_line = ~loop_sel ? serial_in_pin :
		(swire_sel ? serial_out_pin_in :
		tx_line_reg);

	always @(posedge clk) begin
		if (rst) begin
			serial_out_pin_out <= 1'b1;
			serial_out_pin_oe_n <= 1'b1;
			serial_in_released <= 1'b1;
		end else begin
			serial_out_pin_out <= tx_line_reg;
			serial_out_pin_oe_n <= ~(tx_on &
				(~single_wire | dir_sel));
			serial_in_released <= ~rx_on | loop_sel;
		end
	end

	// ----------------------------------------
	// Receiver and idle detection
	// ----------------------------------------
	reg rx_state_reg;
	reg [15:0] rx_tmr_reg;
	reg [3:0] rx_bit_reg;
	reg [9:0] rx_shift_reg;
	reg [3:0] idle_cnt_reg;
	reg idle_armed_reg;
	wire [9:0] rx_shift_new = {rx_line, rx_shift_reg[9:1]};
	wire [8:0] rx_char = nine_sel ? rx_shift_new[8:0] :
		{1'b0, rx_shift_new[8:1]};
	wire rx_par_msb = nine_sel ? rx_char[8] : rx_char[7];
	wire rx_par_bad = pe_sel & (rx_par_msb !=
		parity_bit(rx_char, nine_sel, pt_sel));
	wire rx_tick = (rx_tmr_reg == 16'h0000);

	always @(posedge clk) begin
		if (rst) begin
			rx_state_reg <= ST_IDLE;
			rx_tmr_reg <= 16'h0000;
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= 10'h000;
			idle_cnt_reg <= 4'h0;
			idle_armed_reg <= 1'b0;
			rx_data <= 9'h000;
			rx_strobe <= 1'b0;
			rx_parity_err <= 1'b0;
			rx_frame_err <= 1'b0;
			idle_strobe <= 1'b0;
		end else begin
			rx_strobe <= 1'b0;
			idle_strobe <= 1'b0;
			rx_tmr_reg <= rx_tick ? BIT_LAST : rx_tmr_reg - 1'b1;
			if (~rx_on) begin
				rx_state_reg <= ST_IDLE;
				idle_cnt_reg <= 4'h0;
				idle_armed_reg <= 1'b0;
			end else begin
				case (rx_state_reg)
				ST_IDLE: begin
					if (~rx_line) begin
						rx_state_reg <= ST_BUSY;
						rx_tmr_reg <= BIT_HALF;
						rx_bit_reg <= 4'h0;
						idle_cnt_reg <= 4'h0;
					end else if (rx_tick && idle_cnt_reg != frame_bits) begin
						idle_cnt_reg <= idle_cnt_reg + 1'b1;
						if (idle_cnt_reg + 1'b1 == frame_bits &&
							idle_armed_reg) begin
							idle_strobe <= 1'b1;
							idle_armed_reg <= 1'b0;
						end
					end
				end
				default: begin
					if (rx_tick) begin
						if (ilt_sel)
							idle_cnt_reg <= 4'h0;
						else if (rx_line && rx_bit_reg != 4'h0)
							idle_cnt_reg <= idle_cnt_reg + 1'b1;
						else
							idle_cnt_reg <= 4'h0;
						rx_bit_reg <= rx_bit_reg + 1'b1;
						if (rx_bit_reg == 4'h0) begin
							if (rx_line)
								rx_state_reg <= ST_IDLE;
						end else begin
							rx_shift_reg <= rx_shift_new;
						end
						if (rx_bit_reg == frame_bits - 1'b1) begin
							rx_state_reg <= ST_IDLE;
							idle_armed_reg <= 1'b1;
							if (~rwu_sel) begin
								rx_data <= rx_char;
								rx_strobe <= 1'b1;
								rx_parity_err <= rx_par_bad;
								rx_frame_err <= ~rx_shift_new[9];
							end
						end
					end
				end
				endcase
			end
		end
	end
endmodule

// ---- include/sflc_defs.vh ----
/*
 Constants for the serial frame and loop control block: register
 addresses, field positions, reset values and frame lengths.
 Assumes inclusion by the block's design file only.
*/
`ifndef SFLC_DEFS_VH
`define SFLC_DEFS_VH

// ----------------------------------------
// Address map
// ----------------------------------------
`define SFLC_BASE_BLOCKING 16'h0200
`define SFLC_BASE_NONBLOCK 16'h0300
`define SFLC_OFF_CTRL1 16'h0042
`define SFLC_OFF_CTRL2 16'h0043
`define SFLC_OFF_CTRL3 16'h0046

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SFLC_CTRL1_RESET 8'h00
`define SFLC_CTRL2_RESET 8'h00
`define SFLC_CTRL3_RESET 8'h00

// ----------------------------------------
// First control register fields
// ----------------------------------------
`define SFLC_C1_LOOP 7
`define SFLC_C1_SWIRE 5
`define SFLC_C1_NINE 4
`define SFLC_C1_ILT 2
`define SFLC_C1_PE 1
`define SFLC_C1_PT 0

// ----------------------------------------
// Second control register fields
// ----------------------------------------
`define SFLC_C2_TIE 7
`define SFLC_C2_TX_DONE_IRQ_EN 6
`define SFLC_C2_RIE 5
`define SFLC_C2_IDLE_IRQ_EN 4
`define SFLC_C2_TE 3
`define SFLC_C2_RE 2
`define SFLC_C2_RWU 1
`define SFLC_C2_SBK 0

// ----------------------------------------
// Third control register fields
// ----------------------------------------
`define SFLC_C3_DIR 5

// ----------------------------------------
// Frame lengths in bit times
// ----------------------------------------
`define SFLC_FRAME_BITS_8 4'hA
`define SFLC_FRAME_BITS_9 4'hB

`endif

// ---- verification/sflc_top_asserts.sv ----
/* Port checker for sflc_top.
 Assumes a synchronous active-high reset and bytes on the bus. */
`timescale 1ns/1ns
module sflc_chk #(
	parameter BIT_CYCLES = 16
) (
	input wire clk,
	input wire rst,
	input wire [15:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_wdata,
	input wire [7:0] bus_rdata,
	input wire rx_strobe,
	input wire rx_parity_err,
	input wire idle_strobe,
	input wire serial_in_pin,
	input wire serial_in_released,
	input wire serial_out_pin_out,
	input wire serial_out_pin_oe_n
);
	// ----------
	// Shadows of the control registers and line run counters
	// ----------
	reg [7:0] c1_reg;
	reg [7:0] c2_reg;
	reg c3_reg;
	reg [15:0] low_reg;
	reg [15:0] high_reg;
	wire [15:0] a = bus_addr & 16'hfeff;
	wire hit = a == 16'h0242 || a == 16'h0243 || a == 16'h0246;
	wire loop = c1_reg[7];
	wire rx_on = c2_reg[2];
	wire hold_off = loop && c1_reg[5] && !c3_reg;
	always @(posedge clk) begin
		if (rst) begin
			c1_reg <= 8'h00;
			c2_reg <= 8'h00;
			c3_reg <= 1'b0;
		end else if (bus_wr) begin
			if (a == 16'h0242) c1_reg <= bus_wdata;
			if (a == 16'h0243) c2_reg <= bus_wdata;
			if (a == 16'h0246) c3_reg <= bus_wdata[5];
		end
		low_reg <= (serial_out_pin_out || rst) ? 16'h0000 :
			low_reg + 16'h0001;
		high_reg <= (serial_in_pin && !rst) ? high_reg + 16'h0001 :
			16'h0000;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RDATA_HOLD: assert property (
		!bus_rd |=> $stable(bus_rdata)) else $error("rdata moved");
	AST_UNMAPPED: assert property (
		bus_rd && !hit |=> bus_rdata == 8'h00) else $error("hole not 0");
	AST_CTRL2_READ: assert property (
		bus_rd && a == 16'h0243 |=> bus_rdata == $past(c2_reg))
		else $error("ctrl2 readback");
	AST_RELEASE: assert property (
		$stable(c1_reg) && $stable(c2_reg) |=>
		serial_in_released == ($past(loop) || !$past(rx_on)))
		else $error("input pin release");
	AST_DRIVE: assert property (
		$stable(c1_reg) && $stable(c2_reg) && $stable(c3_reg) && c2_reg[3]
		|=> serial_out_pin_oe_n == $past(hold_off))
		else $error("output enable");
	AST_CHAR_BITS: assert property (
		$rose(serial_out_pin_out) |-> low_reg % BIT_CYCLES == 0)
		else $error("low run not whole bits");
	AST_IDLE_AFTER_STOP: assert property (
		idle_strobe && c1_reg[2] && !loop |->
		high_reg >= (c1_reg[4] ? 11 : 10) * BIT_CYCLES)
		else $error("idle too early");
	AST_NO_PARITY: assert property (
		rx_strobe && !c1_reg[1] |-> !rx_parity_err)
		else $error("parity flag while off");
endmodule

bind sflc_top sflc_chk #(
	.BIT_CYCLES(BIT_CYCLES)
) chk (
	.clk(clk),
	.rst(rst),
	.bus_addr(bus_addr),
	.bus_wr(bus_wr),
	.bus_rd(bus_rd),
	.bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata),
	.rx_strobe(rx_strobe),
	.rx_parity_err(rx_parity_err),
	.idle_strobe(idle_strobe),
	.serial_in_pin(serial_in_pin),
	.serial_in_released(serial_in_released),
	.serial_out_pin_out(serial_out_pin_out),
	.serial_out_pin_oe_n(serial_out_pin_oe_n)
);

// ---- verification/sflc_far.sv ----
/* Remote serial node: sends and receives framed characters.
 Assumes idle-high lines clocked by the bench clock. */
`timescale 1ns/1ns
module sflc_far #(
	parameter BIT_CYCLES = 4
) (
	input wire clk,
	input wire go,
	input wire listen,
	input wire [8:0] data,
	input wire [3:0] bits,
	input wire rx_line,
	output reg line = 1'b1,
	output reg busy = 1'b0,
	output reg [8:0] far_data = 9'h000,
	output reg far_stb = 1'b0
);
	// ----------
	// Start, data LSB first, stop; no echo of own frames
	// ----------
	reg [8:0] d;
	reg [8:0] r;
	integer i;
	integer j;
	always @(posedge clk) if (go && !busy) begin
		busy <= 1'b1;
		d = data;
		line <= 1'b0;
		repeat (BIT_CYCLES) @(posedge clk);
		for (i = 0; i < bits; i = i + 1) begin
			line <= d[i];
			repeat (BIT_CYCLES) @(posedge clk);
		end
		line <= 1'b1;
		repeat (BIT_CYCLES) @(posedge clk);
		busy <= 1'b0;
	end
	always @(negedge rx_line) if (listen && !busy) begin
		r = 9'h000;
		repeat (BIT_CYCLES / 2) @(posedge clk);
		for (j = 0; j < bits; j = j + 1) begin
			repeat (BIT_CYCLES) @(posedge clk);
			r[j] = rx_line;
		end
		repeat (BIT_CYCLES) @(posedge clk);
		far_data <= r;
		far_stb <= 1'b1;
		@(posedge clk);
		far_stb <= 1'b0;
	end
endmodule

// ---- verification/tb_top.sv ----
/* Bench for sflc_top with a remote node on its pins.
 Assumes the checker binds itself. */
`timescale 1ns/1ns
module tb_top;
	// ----------
	// Signals, scoreboard and tasks
	// ----------
	localparam BC = 4;
	reg clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, rd_d = 1'b0;
	reg tx_valid = 1'b0, go = 1'b0, listen = 1'b1;
	reg [15:0] bus_addr = 16'h0000;
	reg [7:0] bus_wdata = 8'h00, c;
	reg [8:0] tx_data = 9'h000, f_data = 9'h000, d, e;
	reg [3:0] bits = 4'h8;
	wire [7:0] rdat;
	wire [8:0] rx_data, far_data;
	wire tx_ready, rx_strobe, perr, ferr, idle, rel, pout, oe_n, pl, pb, fstb;
	wire sh = oe_n ? pl : pout;
	wire [10:0] rx_all = {ferr, perr, rx_data};
	reg [10:0] qd[$], qr[$], qf[$];
	integer miscompares = 0, comparisons = 0, seed = 47, idle_n = 0, m, n, i;
	always #20 clk = ~clk;
	sflc_top #(.BIT_CYCLES(BC)) uut (.clk(clk), .rst(rst),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(rdat), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_strobe(rx_strobe), .rx_parity_err(perr), .rx_frame_err(ferr),
		.idle_strobe(idle), .serial_in_pin(pl), .serial_in_released(rel),
		.serial_out_pin_in(sh), .serial_out_pin_out(pout),
		.serial_out_pin_oe_n(oe_n));
	sflc_far #(.BIT_CYCLES(BC)) far (.clk(clk), .go(go), .listen(listen),
		.data(f_data), .bits(bits), .rx_line(sh), .line(pl), .busy(pb),
		.far_data(far_data), .far_stb(fstb));
	task rep(input [39:0] nm, input [10:0] x, input [10:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== x) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, x, g);
			end
		end
	endtask
	task chk_rd; rep("rdata", qd.size() ? qd.pop_front() : 'x, rdat);
	endtask
	task chk_rx; rep("rx", qr.size() ? qr.pop_front() : 'x, rx_all);
	endtask
	task chk_far; rep("far", qf.size() ? qf.pop_front() : 'x, far_data);
	endtask
	task stop_test;
		begin
			$display("Counts: %0d compared, %0d bad", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task wr(input [15:0] a, input [7:0] v);
		begin
			bus_addr <= a;
			bus_wdata <= v;
			bus_wr <= 1'b1;
			@(posedge clk);
			bus_wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [15:0] a, input [7:0] v);
		begin
			bus_addr <= a;
			bus_rd <= 1'b1;
			qd.push_back(v);
			@(posedge clk);
			bus_rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	task settle(input integer lim);
		integer k;
		begin
			for (k = 0; k < lim && (qr.size() || qf.size() || pb); k = k + 1)
				@(posedge clk);
			if (k == lim) begin
				miscompares = miscompares + 1;
				stop_test;
			end
		end
	endtask
	task push(input [8:0] v);
		begin
			tx_data <= v;
			tx_valid <= 1'b1;
			@(posedge clk);
			tx_valid <= 1'b0;
			@(posedge clk);
		end
	endtask
	task send(input [8:0] v);
		begin
			f_data <= v;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
		end
	endtask
	function [8:0] fr(input [8:0] v, input [7:0] k);
		begin
			fr = k[4] ? v : {1'b0, v[7:0]};
			if (k[1] && k[4]) fr[8] = ^v[7:0] ^ k[0];
			if (k[1] && !k[4]) fr[7] = ^v[6:0] ^ k[0];
		end
	endfunction
	always @(posedge clk) begin
		rd_d <= bus_rd;
		if (rd_d) chk_rd;
		if (rx_strobe === 1'b1) chk_rx;
		if (fstb) chk_far;
		if (idle === 1'b1) idle_n = idle_n + 1;
	end
	// ----------
	// Scenarios
	// ----------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(16'h0242, 8'h00);
		rd(16'h0343, 8'h00);
		c = $random(seed) & 8'hfe;
		wr(16'h0343, c);
		rd(16'h0243, c);
		rd(16'h0244, 8'h00);
		wr(16'h0246, 8'hff);
		rd(16'h0346, 8'h20);
		wr(16'h0246, 8'h00);
		wr(16'h0243, 8'h0c);
		$display("Test registers done");
		for (m = 0; m < 16; m = m + 1) begin
			c = ($random(seed) & 8'h20) | {3'b000, m[3], 1'b0, m[2:0]};
			wr(16'h0242, c);
			bits <= c[4] ? 4'h9 : 4'h8;
			idle_n = 0;
			d = $random(seed);
			qf.push_back(fr(d, c));
			push(d);
			settle(500);
			e = fr($random(seed), c) ^ {m[0] & c[4], m[0] & !c[4], 7'h00};
			qr.push_back({1'b0, m[0] & c[1], e});
			send(e);
			settle(500);
			repeat (14 * BC) @(posedge clk);
			rep("idle", 1, idle_n);
		end
		$display("Test formats done");
		listen <= 1'b0;
		bits <= 4'h8;
		wr(16'h0242, 8'h80);
		send($random(seed));
		d = $random(seed);
		qr.push_back({3'b000, d[7:0]});
		push(d);
		settle(500);
		rep("rel", 1, rel);
		listen <= 1'b1;
		wr(16'h0242, 8'ha0);
		wr(16'h0246, 8'h20);
		d = $random(seed);
		qr.push_back({3'b000, d[7:0]});
		qf.push_back({3'b000, d[7:0]});
		push(d);
		settle(500);
		wr(16'h0246, 8'h00);
		d = $random(seed);
		qr.push_back({3'b000, d[7:0]});
		send(d);
		settle(500);
		$display("Test loop modes done");
		wr(16'h0242, 8'h00);
		wr(16'h0243, 8'h04);
		tx_valid <= 1'b1;
		n = 0;
		for (i = 0; i < 40 && n == i; i = i + 1) begin
			d = $random(seed);
			tx_data <= d;
			@(posedge clk);
			if (tx_ready === 1'b1) begin
				qf.push_back({3'b000, d[7:0]});
				n = n + 1;
			end
		end
		tx_valid <= 1'b0;
		rep("fill", 32, n);
		wr(16'h0243, 8'h0c);
		settle(3000);
		$display("Test buffer done");
		stop_test;
	end
endmodule
